/* core/lbp_core.sv */
/*
 * ladder boolean processor: one-bit accumulator, result stack, block join
 * and edge triggers, executing one offered instruction per cycle.
 * assumes the fetch stage presents instr with instrValid and the operand
 * bit already read from device memory in the same cycle, on sys_clk.
 */
// Function
// - load open contact saves then loads
// - series open contact ANDs accumulator
// - parallel open contact ORs accumulator
// - load closed contact saves, loads inverted
// - series closed contact ANDs inverted bit
// - parallel closed contact ORs inverted bit
// - closed contact true when bit off
// - block joins: no operand, one step
// - join saved result with accumulator
// - push, peek, pop stack instructions
// - push increments, pop decrements, depth 31
// - device operand instructions other than extended take 1-2 steps
// - contacts accept direct input, not output
// - coil and set accept output, latch on
// - extended edge detect: five steps, no direct
// - complement inverts accumulator, one step
// - master control takes level, one step
// - halt stops further execution
// - circuit edge triggers on preceding result
`timescale 1ns/1ns
`include "lbp_params.svh"

module lbp_core (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic instrValid,
    input wire lbp_pkg::lbp_instr_t instr,
    input wire logic operandBit,
    input wire logic edgeHistory,
    input wire logic [3:0] mcLevel,
    output lbp_pkg::lbp_result_t result,
    output logic coilWrite,
    output logic coilValue,
    output logic [3:0] mcDepth,
    output logic stackFault,
    output logic [4:0] stackPtr
);
    import lbp_pkg::*;

    // ================================================================
    // decode
    logic legal;
    logic [2:0] stepCount;
    logic acc;
    logic [31:0] stack;
    lbp_state_t state;
    logic prevCircuit;
    logic exec;
    logic next_acc;
    logic contactBit;
    logic closedBit;
    logic doPush;
    logic doPop;
    logic stackTop;

    lbp_operand_check u_check (
        .instr(instr),
        .legal(legal),
        .steps(stepCount)
    );

    // one instruction per cycle so each sees the accumulator of the last
    assign exec = instrValid && legal && (state == LBP_RUN);
    assign contactBit = operandBit;
    assign closedBit = ~operandBit;
    assign stackTop = stack[stackPtr];

    always_comb begin
        next_acc = acc;
        doPush = 1'b0;
        doPop = 1'b0;
        case (instr.opcode)
            `LBP_OP_LD: begin
                doPush = 1'b1;
                next_acc = contactBit;
            end
            `LBP_OP_AND: next_acc = acc & contactBit;
            `LBP_OP_OR: next_acc = acc | contactBit;
            `LBP_OP_LDI: begin
                doPush = 1'b1;
                next_acc = closedBit;
            end
            `LBP_OP_ANI: next_acc = acc & closedBit;
            `LBP_OP_ORI: next_acc = acc | closedBit;
            `LBP_OP_LDP: begin
                doPush = 1'b1;
                next_acc = contactBit & ~edgeHistory;
            end
            `LBP_OP_LDF: begin
                doPush = 1'b1;
                next_acc = ~contactBit & edgeHistory;
            end
            `LBP_OP_ANB: begin
                doPop = 1'b1;
                next_acc = stackTop & acc;
            end
            `LBP_OP_ORB: begin
                doPop = 1'b1;
                next_acc = stackTop | acc;
            end
            `LBP_OP_PUSH: doPush = 1'b1;
            `LBP_OP_PEEK: next_acc = stackTop;
            `LBP_OP_POP: begin
                doPop = 1'b1;
                next_acc = stackTop;
            end
            `LBP_OP_INV: next_acc = ~acc;
            `LBP_OP_NPTRIG: next_acc = acc & ~prevCircuit;
            `LBP_OP_PNTRIG: next_acc = ~acc & prevCircuit;
            `LBP_OP_FBNP: next_acc = acc & ~edgeHistory;
            `LBP_OP_FBPN: next_acc = ~acc & edgeHistory;
            `LBP_OP_EXTRISE: next_acc = contactBit & ~edgeHistory;
            `LBP_OP_EXTFALL: next_acc = ~contactBit & edgeHistory;
            default: next_acc = acc;
        endcase
    end

    // ================================================================
    // accumulator
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            acc <= 1'b0;
        end else if (exec) begin
            acc <= next_acc;
        end
    end

    // edge triggers compare against the circuit value at the previous trigger
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prevCircuit <= 1'b0;
        end else if (exec && (instr.opcode == `LBP_OP_NPTRIG
                || instr.opcode == `LBP_OP_PNTRIG)) begin
            prevCircuit <= acc;
        end
    end

    // ================================================================
    // result stack; overflow or underflow is refused and flagged
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stackPtr <= `LBP_ZERO_PTR;
            stackFault <= 1'b0;
        end else if (exec && doPush) begin
            if (stackPtr == `LBP_STACK_MAX) begin
                stackFault <= 1'b1;
            end else begin
                stackPtr <= stackPtr + 5'h01;
            end
        end else if (exec && doPop) begin
            if (stackPtr == `LBP_ZERO_PTR) begin
                stackFault <= 1'b1;
            end else begin
                stackPtr <= stackPtr - 5'h01;
            end
        end
    end

    // slot 0 is never written after reset; entries live at 1..31
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stack <= 32'h0000_0000;
        end else if (exec && doPush && stackPtr != `LBP_STACK_MAX) begin
            stack[stackPtr + 5'h01] <= acc;
        end
    end

    // ================================================================
    // halt and master control
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= LBP_RUN;
        end else begin
            case (state)
                LBP_RUN: begin
                    if (exec && instr.opcode == `LBP_OP_HALT) begin
                        state <= LBP_HALT;
                    end
                end
                LBP_HALT: state <= LBP_HALT;
                default: state <= LBP_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mcDepth <= 4'h0;
        end else if (exec && instr.opcode == `LBP_OP_MCS) begin
            mcDepth <= mcLevel;
        end else if (exec && instr.opcode == `LBP_OP_MCR) begin
            mcDepth <= mcLevel;
        end
    end

    // ================================================================
    // coil writes: SET only ever writes ON, so the target stays latched
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            coilWrite <= 1'b0;
            coilValue <= 1'b0;
        end else begin
            coilWrite <= 1'b0;
            coilValue <= 1'b0;
            if (exec && instr.opcode == `LBP_OP_OUT) begin
                coilWrite <= 1'b1;
                coilValue <= acc;
            end else if (exec && instr.opcode == `LBP_OP_SET && acc) begin
                coilWrite <= 1'b1;
                coilValue <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            result <= '0;
        end else begin
            result.acc <= exec ? next_acc : acc;
            result.steps <= stepCount;
            result.illegal <= instrValid && !legal;
            result.halted <= (state == LBP_HALT) || (exec && instr.opcode == `LBP_OP_HALT);
        end
    end

    // ================================================================
    // checks
    a_series_open: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_AND |=> acc == ($past(acc) & $past(operandBit)))
        else $error("series open wrong");
    a_par_open: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_OR |=> acc == ($past(acc) | $past(operandBit)))
        else $error("parallel open wrong");
    a_load_closed: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_LDI |=> acc == !$past(operandBit))
        else $error("load closed wrong");
    a_load_open: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_LD && stackPtr != `LBP_STACK_MAX
        |=> acc == $past(operandBit) && stackPtr == $past(stackPtr) + 5'h01)
        else $error("load open wrong");
    a_series_closed: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_ANI |=> acc == ($past(acc) & !$past(operandBit)))
        else $error("series closed wrong");
    a_par_closed: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_ORI |=> acc == ($past(acc) | !$past(operandBit)))
        else $error("parallel closed wrong");
    a_peek_ptr: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_PEEK |=> $stable(stackPtr))
        else $error("peek moved pointer");
    a_invert_acc: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_INV |=> acc != $past(acc))
        else $error("invert wrong");
    a_halt_stays: assert property (@(posedge sys_clk) disable iff (srst)
        state == LBP_HALT |=> state == LBP_HALT && $stable(acc))
        else $error("ran after halt");
    a_ext_steps: assert property (@(posedge sys_clk) disable iff (srst)
        instr.opcode == `LBP_OP_EXTRISE |=> result.steps == `LBP_STEPS_EXT)
        else $error("extended steps wrong");

    // ================================================================
    // stack, join, coil, edge and operand class checks
    a_block_series: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_ANB && stackPtr != `LBP_ZERO_PTR
        |=> acc == ($past(stackTop) & $past(acc)) && stackPtr == $past(stackPtr) - 5'h01)
        else $error("block series join wrong");
    a_block_par: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_ORB && stackPtr != `LBP_ZERO_PTR
        |=> acc == ($past(stackTop) | $past(acc)) && stackPtr == $past(stackPtr) - 5'h01)
        else $error("block parallel join wrong");
    a_push_ptr: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_PUSH && stackPtr != `LBP_STACK_MAX
        |=> stackPtr == $past(stackPtr) + 5'h01 && $stable(acc))
        else $error("push wrong");
    a_pop_ptr: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_POP && stackPtr != `LBP_ZERO_PTR
        |=> acc == $past(stackTop) && stackPtr == $past(stackPtr) - 5'h01)
        else $error("pop wrong");
    a_stack_fault: assert property (@(posedge sys_clk) disable iff (srst)
        exec && doPush && stackPtr == `LBP_STACK_MAX |=> stackFault && $stable(stackPtr))
        else $error("overflow not refused");
    a_coil_out: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_OUT |=> coilWrite && coilValue == $past(acc))
        else $error("coil drive wrong");
    a_set_latch: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_SET |=> coilWrite == $past(acc) && (!coilWrite || coilValue))
        else $error("latch on wrong");
    a_circuit_rise: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_NPTRIG |=> acc == ($past(acc) & !$past(prevCircuit)))
        else $error("rising trigger wrong");
    a_circuit_fall: assert property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_PNTRIG |=> acc == (!$past(acc) & $past(prevCircuit)))
        else $error("falling trigger wrong");
    a_class_refused: assert property (@(posedge sys_clk) disable iff (srst)
        instrValid && !legal |=> result.illegal && $stable(acc))
        else $error("illegal class not refused");

    c_push_pop: cover property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_PUSH ##[1:8] exec && instr.opcode == `LBP_OP_POP);
    c_block_join: cover property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_ANB);
    c_halt: cover property (@(posedge sys_clk) disable iff (srst) state == LBP_HALT);
    c_stack_fault: cover property (@(posedge sys_clk) disable iff (srst) $rose(stackFault));
    c_circuit_edge: cover property (@(posedge sys_clk) disable iff (srst)
        exec && instr.opcode == `LBP_OP_PNTRIG && next_acc);
endmodule

/* core/lbp_params.svh */
/*
 * constants of the ladder boolean processor: opcodes, device classes,
 * step counts and stack depth.
 * assumes nothing; included by the package users.
 */
`ifndef LBP_PARAMS_SVH
`define LBP_PARAMS_SVH

// ====================================================================
// opcodes
`define LBP_OP_NOP 5'h00
`define LBP_OP_LD 5'h01
`define LBP_OP_AND 5'h02
`define LBP_OP_OR 5'h03
`define LBP_OP_LDI 5'h04
`define LBP_OP_ANI 5'h05
`define LBP_OP_ORI 5'h06
`define LBP_OP_ANB 5'h07
`define LBP_OP_ORB 5'h08
`define LBP_OP_PUSH 5'h09
`define LBP_OP_PEEK 5'h0a
`define LBP_OP_POP 5'h0b
`define LBP_OP_OUT 5'h0c
`define LBP_OP_SET 5'h0d
`define LBP_OP_MCS 5'h0e
`define LBP_OP_MCR 5'h0f
`define LBP_OP_EXTRISE 5'h10
`define LBP_OP_EXTFALL 5'h11
`define LBP_OP_INV 5'h12
`define LBP_OP_NPTRIG 5'h13
`define LBP_OP_PNTRIG 5'h14
`define LBP_OP_FBNP 5'h15
`define LBP_OP_FBPN 5'h16
`define LBP_OP_HALT 5'h17
`define LBP_OP_PLS 5'h18
`define LBP_OP_PLF 5'h19
`define LBP_OP_LDP 5'h1a
`define LBP_OP_LDF 5'h1b

// ====================================================================
// device classes
`define LBP_DC_DIRIN 4'h0
`define LBP_DC_DIROUT 4'h1
`define LBP_DC_LAST 4'hc

// ====================================================================
// step counts and stack
`define LBP_STEPS_ONE 3'h1
`define LBP_STEPS_TWO 3'h2
`define LBP_STEPS_EXT 3'h5
`define LBP_STACK_MAX 5'h1f
`define LBP_ZERO_PTR 5'h00

`endif

/* core/lbp_pkg.sv */
/*
 * types of the ladder boolean processor.
 * assumes lbp_params.svh is on the include path.
 */
package lbp_pkg;
    // ================================================================
    // instruction as offered by the fetch stage
    typedef struct packed {
        logic [4:0] opcode;
        logic [3:0] devClass;
        logic longForm;
    } lbp_instr_t;

    // ================================================================
    // result of one executed instruction
    typedef struct packed {
        logic acc;
        logic [2:0] steps;
        logic illegal;
        logic halted;
    } lbp_result_t;

    typedef enum logic [1:0] {
        LBP_RUN = 2'b00,
        LBP_HALT = 2'b01
    } lbp_state_t;
endpackage

/* core/lbp_operand_check.sv */
/*
 * operand class legality and step count of one instruction.
 * assumes a decoded opcode and device class from the same clock domain.
 */
`timescale 1ns/1ns
`include "lbp_params.svh"

module lbp_operand_check (
    input wire lbp_pkg::lbp_instr_t instr,
    output logic legal,
    output logic [2:0] steps
);
    import lbp_pkg::*;

    logic inRange;

    assign inRange = (instr.devClass <= `LBP_DC_LAST);

    always_comb begin
        legal = 1'b1;
        steps = instr.longForm ? `LBP_STEPS_TWO : `LBP_STEPS_ONE;
        case (instr.opcode)
            `LBP_OP_LD, `LBP_OP_AND, `LBP_OP_OR, `LBP_OP_LDI, `LBP_OP_ANI, `LBP_OP_ORI,
            `LBP_OP_LDP, `LBP_OP_LDF: begin
                legal = inRange && (instr.devClass != `LBP_DC_DIROUT);
            end
            `LBP_OP_OUT, `LBP_OP_SET, `LBP_OP_PLS, `LBP_OP_PLF: begin
                legal = inRange && (instr.devClass != `LBP_DC_DIRIN);
            end
            `LBP_OP_FBNP, `LBP_OP_FBPN: begin
                legal = inRange && (instr.devClass != `LBP_DC_DIRIN)
                    && (instr.devClass != `LBP_DC_DIROUT);
            end
            `LBP_OP_EXTRISE, `LBP_OP_EXTFALL: begin
                steps = `LBP_STEPS_EXT;
                legal = inRange && (instr.devClass != `LBP_DC_DIRIN)
                    && (instr.devClass != `LBP_DC_DIROUT);
            end
            `LBP_OP_MCS, `LBP_OP_MCR: begin
                steps = `LBP_STEPS_ONE;
            end
            default: begin
                steps = `LBP_STEPS_ONE;
            end
        endcase
    end
endmodule

/* bench/testbench.sv */
/*
 * self-checking bench for the ladder boolean processor core: contacts,
 * block joins, result stack, operand classes, coil, complement, master
 * control and halt.
 * assumes lbp_pkg is compiled first and lbp_params.svh is on the path.
 */
`timescale 1ns/1ns
`include "lbp_params.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module testbench;
    import lbp_pkg::*;
    logic sys_clk;
    logic srst;
    logic instrValid;
    lbp_instr_t instr;
    logic operandBit;
    logic edgeHistory;
    logic [3:0] mcLevel;
    lbp_result_t result;
    logic coilWrite;
    logic coilValue;
    logic [3:0] mcDepth;
    logic stackFault;
    logic [4:0] stackPtr;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    lbp_core u_lbp_core (
        .sys_clk(sys_clk), .srst(srst), .instrValid(instrValid), .instr(instr),
        .operandBit(operandBit), .edgeHistory(edgeHistory), .mcLevel(mcLevel),
        .result(result), .coilWrite(coilWrite), .coilValue(coilValue),
        .mcDepth(mcDepth), .stackFault(stackFault), .stackPtr(stackPtr)
    );

    // ================================================================
    // clock, timeout and verdict
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // the whole run needs well under 500 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            end_sim();
        end
    end

    // ================================================================
    // drivers
    task automatic do_reset();
        @(posedge sys_clk);
        srst <= 1'b1;
        instrValid <= 1'b0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        #1;
    endtask

    // one idle cycle follows each instruction so it is taken exactly once
    task automatic op(input logic [4:0] opc, input logic [3:0] cls, input logic lf,
                      input logic b);
        @(posedge sys_clk);
        instrValid <= 1'b1;
        instr <= {opc, cls, lf};
        operandBit <= b;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        #1;
    endtask

    task automatic c(input logic [4:0] opc, input logic b);
        op(opc, 4'h2, 1'b0, b);
    endtask

    // ================================================================
    // scenarios
    task automatic t_reset_vals();
        do_reset();
        `CHK("ptr", 5'h00, stackPtr)
        `CHK("result", 6'h00, result)
        `CHK("coil", 1'b0, coilWrite)
        `CHK("fault", 1'b0, stackFault)
        `CHK("depth", 4'h0, mcDepth)
        $display("test reset values done");
    endtask

    task automatic t_contacts();
        do_reset();
        c(`LBP_OP_LD, 1'b1);
        `CHK("acc", 1'b1, result.acc)
        `CHK("ptr", 5'h01, stackPtr)
        c(`LBP_OP_AND, 1'b0);
        `CHK("acc", 1'b0, result.acc)
        c(`LBP_OP_OR, 1'b1);
        `CHK("acc", 1'b1, result.acc)
        c(`LBP_OP_LDI, 1'b1);
        `CHK("acc", 1'b0, result.acc)
        `CHK("ptr", 5'h02, stackPtr)
        c(`LBP_OP_ORI, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        c(`LBP_OP_ANI, 1'b1);
        `CHK("acc", 1'b0, result.acc)
        c(`LBP_OP_LDI, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        c(`LBP_OP_ORB, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        `CHK("steps", `LBP_STEPS_ONE, result.steps)
        `CHK("ptr", 5'h02, stackPtr)
        c(`LBP_OP_ANB, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        `CHK("ptr", 5'h01, stackPtr)
        c(`LBP_OP_ANB, 1'b0);
        `CHK("acc", 1'b0, result.acc)
        $display("test contacts done");
    endtask

    task automatic t_stack();
        do_reset();
        c(`LBP_OP_LD, 1'b1);
        c(`LBP_OP_PUSH, 1'b0);
        `CHK("ptr", 5'h02, stackPtr)
        c(`LBP_OP_AND, 1'b0);
        c(`LBP_OP_PEEK, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        `CHK("ptr", 5'h02, stackPtr)
        c(`LBP_OP_AND, 1'b0);
        c(`LBP_OP_POP, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        `CHK("ptr", 5'h01, stackPtr)
        `CHK("steps", `LBP_STEPS_ONE, result.steps)
        do_reset();
        c(`LBP_OP_POP, 1'b0);
        `CHK("ptr", 5'h00, stackPtr)
        `CHK("fault", 1'b1, stackFault)
        do_reset();
        repeat (31) c(`LBP_OP_PUSH, 1'b0);
        `CHK("ptr", `LBP_STACK_MAX, stackPtr)
        `CHK("fault", 1'b0, stackFault)
        c(`LBP_OP_PUSH, 1'b0);
        `CHK("ptr", `LBP_STACK_MAX, stackPtr)
        `CHK("fault", 1'b1, stackFault)
        $display("test stack done");
    endtask

    task automatic t_classes();
        do_reset();
        op(`LBP_OP_LD, `LBP_DC_DIRIN, 1'b1, 1'b1);
        `CHK("illegal", 1'b0, result.illegal)
        `CHK("acc", 1'b1, result.acc)
        `CHK("steps", `LBP_STEPS_TWO, result.steps)
        op(`LBP_OP_AND, `LBP_DC_DIROUT, 1'b0, 1'b0);
        `CHK("illegal", 1'b1, result.illegal)
        `CHK("acc", 1'b1, result.acc)
        op(`LBP_OP_OR, 4'hd, 1'b0, 1'b0);
        `CHK("illegal", 1'b1, result.illegal)
        op(`LBP_OP_OUT, `LBP_DC_DIRIN, 1'b0, 1'b0);
        `CHK("coil", 1'b0, coilWrite)
        op(`LBP_OP_SET, `LBP_DC_DIROUT, 1'b0, 1'b0);
        `CHK("coil", 1'b1, coilWrite)
        `CHK("value", 1'b1, coilValue)
        `CHK("steps", `LBP_STEPS_ONE, result.steps)
        op(`LBP_OP_EXTRISE, `LBP_DC_DIRIN, 1'b0, 1'b0);
        `CHK("illegal", 1'b1, result.illegal)
        op(`LBP_OP_EXTFALL, `LBP_DC_LAST, 1'b0, 1'b0);
        `CHK("illegal", 1'b0, result.illegal)
        `CHK("steps", `LBP_STEPS_EXT, result.steps)
        op(`LBP_OP_FBNP, `LBP_DC_DIRIN, 1'b0, 1'b0);
        `CHK("illegal", 1'b1, result.illegal)
        $display("test classes done");
    endtask

    task automatic t_edges();
        do_reset();
        c(`LBP_OP_LD, 1'b1);
        c(`LBP_OP_NPTRIG, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        c(`LBP_OP_NPTRIG, 1'b0);
        `CHK("acc", 1'b0, result.acc)
        c(`LBP_OP_PNTRIG, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        @(posedge sys_clk);
        edgeHistory <= 1'b1;
        c(`LBP_OP_FBNP, 1'b0);
        `CHK("acc", 1'b0, result.acc)
        c(`LBP_OP_FBPN, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        c(`LBP_OP_EXTRISE, 1'b1);
        `CHK("acc", 1'b0, result.acc)
        c(`LBP_OP_EXTFALL, 1'b0);
        `CHK("acc", 1'b1, result.acc)
        @(posedge sys_clk);
        edgeHistory <= 1'b0;
        $display("test edges done");
    endtask

    task automatic t_misc();
        do_reset();
        // back to back: both instructions taken once each, in order
        @(posedge sys_clk);
        instrValid <= 1'b1;
        instr <= {`LBP_OP_LD, 4'h2, 1'b0};
        operandBit <= 1'b0;
        @(posedge sys_clk);
        instr <= {`LBP_OP_OR, 4'h2, 1'b0};
        operandBit <= 1'b1;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        #1;
        `CHK("acc", 1'b1, result.acc)
        `CHK("ptr", 5'h01, stackPtr)
        c(`LBP_OP_INV, 1'b0);
        `CHK("acc", 1'b0, result.acc)
        `CHK("steps", `LBP_STEPS_ONE, result.steps)
        c(`LBP_OP_OUT, 1'b0);
        `CHK("coil", 1'b1, coilWrite)
        `CHK("value", 1'b0, coilValue)
        c(`LBP_OP_SET, 1'b0);
        `CHK("coil", 1'b0, coilWrite)
        @(posedge sys_clk);
        mcLevel <= 4'h5;
        c(`LBP_OP_MCS, 1'b0);
        `CHK("depth", 4'h5, mcDepth)
        `CHK("steps", `LBP_STEPS_ONE, result.steps)
        @(posedge sys_clk);
        mcLevel <= 4'h3;
        c(`LBP_OP_MCR, 1'b0);
        `CHK("depth", 4'h3, mcDepth)
        c(`LBP_OP_HALT, 1'b0);
        `CHK("halted", 1'b1, result.halted)
        c(`LBP_OP_LD, 1'b1);
        `CHK("acc", 1'b0, result.acc)
        `CHK("ptr", 5'h01, stackPtr)
        $display("test misc done");
    endtask

    // ================================================================
    // main sequence
    initial begin
        srst = 1'b1;
        instrValid = 1'b0;
        instr = '0;
        operandBit = 1'b0;
        edgeHistory = 1'b0;
        mcLevel = 4'h0;
        t_reset_vals();
        t_contacts();
        t_stack();
        t_classes();
        t_edges();
        t_misc();
        end_sim();
    end
endmodule
